// ---- common/amx_defs.svh ----
`ifndef AMX_DEFS_SVH
`define AMX_DEFS_SVH
`define AMX_ASP_BASE 16'h8200
`define AMX_ASP_LAST 16'h833c
`define AMX_ASP_PORT_STRIDE 16'h00a0
`define AMX_EQ_MIX_BASE 16'h8b80
`define AMX_EQ_MIX_LAST 16'h8bbc
`define AMX_EFFECTS_ENABLED_FLAGS_ADDR 16'ha804
`define AMX_EQ_EN_ADDR 16'ha808
`define AMX_EQ_MODE_ADDR 16'ha80c
`define AMX_EQ_GAIN_BASE 16'ha810
`define AMX_EQ_STRIDE 16'h0044
`define AMX_EQ_COEF_WORDS 15
`define AMX_SRC_LSB 0
`define AMX_STS_BIT 15
`define AMX_VOL_LSB 17
`define AMX_VOL_RST 7'h40
`define AMX_VOL_MIN 7'h20
`define AMX_VOL_MAX 7'h50
`define AMX_GAIN_RST 5'h0c
`define AMX_GAIN_MAX 5'h18
`define AMX_UNITY 25'sh0040000
`define AMX_GSHIFT 18
`define AMX_CSHIFT 16
`endif

// ---- common/amx_pkg.sv ----
package amx_pkg;
    typedef logic [31:0] amx_word_t;
    typedef logic [15:0] amx_addr_t;
    typedef logic [8:0] amx_src_t;
    typedef logic [6:0] amx_vol_t;
    typedef logic [4:0] amx_gain_t;
    typedef enum logic [1:0] {
        AMX_SHAPE_SHELF = 2'b01,
        AMX_SHAPE_PEAK = 2'b10
    } amx_shape_e;
endpackage : amx_pkg

// ---- rtl/amx_fifo.sv ----
module amx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("amx_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;

    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (in_valid_i && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    chk_fifo_full_stall: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) full && !out_ready_i |=> !in_ready_o)
        else $error("fifo took data while full");
    cov_fifo_full: cover property (@(posedge core_clk_i)
        disable iff (!rst_n_i) full);
endmodule : amx_fifo

// ---- rtl/amx_core.sv ----
// Functional notes
// - Each serial port channel has four-input mixer
// - Port mixer fields live at 0x8200-0x833C
// - Port mixers 32 bit, others cut 24
// - Slow clock refuses enable, active paths kept
// - Per-input status shows which paths enabled
// - Four equalizers, each behind four-input mixer
// - Low band is shelving or peak
// - Bands two to four are peaks
// - Top band is high shelving filter
// - Equalizer mixer fields at 0x8B80-0x8BBC
// - All effects share one sample rate
// - Band coefficients from per-equalizer register block
// - Twelve-bit effects enabled flags at 0xA804
// - One enable per equalizer, reset disabled
// - Band gain code 1 dB steps
// - Zero source select mutes the input
// - Status bit set when path enabled
`include "amx_defs.svh"
module amx_core #(
    parameter int CH = 2,
    parameter int NUM_SRC = 16,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire amx_pkg::amx_addr_t reg_addr_i,
    input wire amx_pkg::amx_word_t reg_wdata_i,
    output amx_pkg::amx_word_t reg_rdata_o,
    output logic reg_ack_o,
    // Core status inputs
    input wire logic core_system_clock_ok_i,
    input wire logic [7:0] fx_other_flags_i,
    // Source samples
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire logic [NUM_SRC*32-1:0] src_data_i,
    input wire logic [NUM_SRC-1:0] src_wide_i,
    // Serial port frames
    output logic asp_valid_o,
    input wire logic asp_ready_i,
    output logic [2*CH*32-1:0] asp_data_o,
    // Equalizer outputs
    output logic [4*24-1:0] eq_data_o
);
    import amx_pkg::*;

    localparam int NASP = 2 * CH;
    localparam int NMIX = NASP + 4;
    localparam int NIN = NMIX * 4;
    localparam int IW = $clog2(NIN);
    localparam int SW = $clog2(NUM_SRC);

    if (CH < 1 || CH > 10 || NUM_SRC < 2 || NUM_SRC > 512 ||
        (1 << SW) != NUM_SRC) begin : g_chk
        $error("amx_core: unsupported CH or NUM_SRC");
    end

    function automatic logic signed [24:0] db_lin(input int db);
        int v;
        int q;
        logic [12:0] t;
        v = db + 36;
        q = v / 6;
        case (v % 6)
            0: t = 13'h1000;
            1: t = 13'h11f6;
            2: t = 13'h1429;
            3: t = 13'h16a1;
            4: t = 13'h1966;
            default: t = 13'h1c82;
        endcase
        db_lin = 25'({12'h0, t} << q);
    endfunction : db_lin

    function automatic int vol_db(input amx_vol_t v);
        if (v <= `AMX_VOL_MIN) vol_db = -32;
        else if (v >= `AMX_VOL_MAX) vol_db = 16;
        else vol_db = int'(v) - int'(`AMX_VOL_RST);
    endfunction : vol_db

    function automatic int gain_db(input amx_gain_t g);
        if (g > `AMX_GAIN_MAX) gain_db = 0;
        else gain_db = int'(g) - int'(`AMX_GAIN_RST);
    endfunction : gain_db

    function automatic logic signed [31:0] sat(input logic signed [63:0] v,
                                               input int w);
        logic signed [63:0] mx;
        mx = (64'sh1 <<< (w - 1)) - 64'sh1;
        if (v > mx) sat = 32'(mx);
        else if (v < -mx - 64'sh1) sat = 32'(-mx - 64'sh1);
        else sat = 32'(v);
    endfunction : sat

    amx_src_t src_q [NIN];
    amx_vol_t vol_q [NIN];
    logic [NIN-1:0] act_q;
    logic [3:0] eq_en_q;
    logic [3:0] eq_mode_q;
    logic [3:0] eq_act_q;
    amx_gain_t gain_q [4][5];
    logic [15:0] coef_q [4][`AMX_EQ_COEF_WORDS];
    logic signed [23:0] lp_q [4][6];
    logic signed [31:0] smp_w [NIN];
    logic signed [55:0] prod_w [NIN];
    logic signed [31:0] mix_out [NMIX];
    logic signed [23:0] eq_x [4];
    logic signed [23:0] eq_y [4];
    logic signed [23:0] lp_d [4][6];
    logic accept;
    logic fifo_ready;
    logic mix_hit;
    logic [IW-1:0] mix_idx;
    logic eq_hit;
    logic [1:0] eq_sel;
    logic [4:0] eq_word;
    amx_word_t rd_d;

    // Shared effects rate: one accepted sample steps every chain
    assign accept = sample_valid_i && fifo_ready;
    assign sample_ready_o = fifo_ready;

    for (genvar k = 0; k < NIN; k++) begin : g_in
        logic [SW-1:0] sidx;
        logic signed [31:0] raw;
        assign sidx = src_q[k][SW-1:0];
        assign raw = src_data_i[sidx*32 +: 32];
        always_comb begin
            if (!act_q[k] || src_q[k] == '0 ||
                int'(src_q[k]) >= NUM_SRC) begin
                smp_w[k] = '0;
            end else if (k < NASP * 4 && src_wide_i[sidx]) begin
                smp_w[k] = raw;
            end else begin
                smp_w[k] = {raw[31:8], 8'h00};
            end
        end
        assign prod_w[k] = smp_w[k] * db_lin(vol_db(vol_q[k]));
    end

    for (genvar m = 0; m < NMIX; m++) begin : g_mix
        logic signed [57:0] sum;
        logic signed [63:0] scaled;
        assign sum = 58'(prod_w[4*m]) + 58'(prod_w[4*m+1]) +
                     58'(prod_w[4*m+2]) + 58'(prod_w[4*m+3]);
        // Equalizer mixers drop to a 24-bit word
        assign scaled = 64'(sum >>> ((m < NASP) ? `AMX_GSHIFT
                                                : `AMX_GSHIFT + 8));
        assign mix_out[m] = sat(scaled, (m < NASP) ? 32 : 24);
    end

    for (genvar c = 0; c < NASP; c++) begin : g_frame
        assign asp_data_o[c*32 +: 32] = mix_out[c];
    end

    for (genvar e = 0; e < 4; e++) begin : g_eq
        logic signed [24:0] cb [5];
        logic signed [52:0] acc;
        amx_shape_e shape;
        assign eq_x[e] = mix_out[NASP+e][23:0];
        assign shape = eq_mode_q[e] ? AMX_SHAPE_PEAK : AMX_SHAPE_SHELF;
        always_comb begin
            logic signed [24:0] diff;
            logic signed [42:0] step;
            diff = '0;
            step = '0;
            for (int j = 0; j < 6; j++) begin
                diff = 25'(eq_x[e]) - 25'(lp_q[e][j]);
                step = diff * $signed({1'b0, coef_q[e][j]});
                lp_d[e][j] = lp_q[e][j] + 24'(step >>> `AMX_CSHIFT);
            end
        end
        always_comb begin
            case (shape)
                AMX_SHAPE_SHELF: cb[0] = 25'(lp_d[e][1]);
                AMX_SHAPE_PEAK: cb[0] = 25'(lp_d[e][1]) -
                                        25'(lp_d[e][0]);
                default: cb[0] = '0;
            endcase
            for (int b = 1; b < 4; b++) begin
                cb[b] = 25'(lp_d[e][b+1]) - 25'(lp_d[e][b]);
            end
            cb[4] = 25'(eq_x[e]) - 25'(lp_d[e][5]);
            acc = '0;
            for (int b = 0; b < 5; b++) begin
                acc = acc + 53'(cb[b] * (db_lin(gain_db(gain_q[e][b])) -
                                        `AMX_UNITY));
            end
            eq_y[e] = 24'(sat(64'(eq_x[e]) + 64'(acc >>> `AMX_GSHIFT),
                              24));
        end
        always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                for (int j = 0; j < 6; j++) lp_q[e][j] <= '0;
                eq_data_o[e*24 +: 24] <= '0;
            end else if (accept) begin
                for (int j = 0; j < 6; j++) begin
                    lp_q[e][j] <= eq_en_q[e] ? lp_d[e][j] : 24'h000000;
                end
                eq_data_o[e*24 +: 24] <= eq_en_q[e] ? eq_y[e]
                                                    : eq_x[e];
            end
        end
    end

    always_comb begin
        logic [15:0] off;
        logic [15:0] loc;
        mix_hit = 1'b0;
        mix_idx = '0;
        eq_hit = 1'b0;
        eq_sel = '0;
        eq_word = '0;
        off = '0;
        loc = '0;
        if (reg_addr_i[1:0] == 2'b00) begin
            if (reg_addr_i >= `AMX_ASP_BASE &&
                reg_addr_i <= `AMX_ASP_LAST) begin
                off = reg_addr_i - `AMX_ASP_BASE;
                if (off >= `AMX_ASP_PORT_STRIDE) begin
                    off = off - `AMX_ASP_PORT_STRIDE;
                    mix_idx = IW'((CH + int'(off[7:4])) * 4 +
                                  int'(off[3:2]));
                end else begin
                    mix_idx = IW'(int'(off[7:4]) * 4 + int'(off[3:2]));
                end
                mix_hit = (int'(off[7:4]) < CH);
            end else if (reg_addr_i >= `AMX_EQ_MIX_BASE &&
                         reg_addr_i <= `AMX_EQ_MIX_LAST) begin
                off = reg_addr_i - `AMX_EQ_MIX_BASE;
                mix_hit = 1'b1;
                mix_idx = IW'((NASP + int'(off[5:4])) * 4 +
                              int'(off[3:2]));
            end
            for (int e = 0; e < 4; e++) begin
                loc = reg_addr_i - `AMX_EQ_GAIN_BASE -
                      16'(e * `AMX_EQ_STRIDE);
                if (reg_addr_i >= `AMX_EQ_GAIN_BASE &&
                    loc < `AMX_EQ_STRIDE) begin
                    eq_hit = 1'b1;
                    eq_sel = 2'(e);
                    eq_word = loc[6:2];
                end
            end
        end
    end

    // Source and volume fields with enable attempt against clock check
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < NIN; k++) begin
                src_q[k] <= '0;
                vol_q[k] <= `AMX_VOL_RST;
            end
            act_q <= '0;
        end else if (reg_wr_i && mix_hit) begin
            src_q[mix_idx] <= reg_wdata_i[`AMX_SRC_LSB +: 9];
            vol_q[mix_idx] <= reg_wdata_i[`AMX_VOL_LSB +: 7];
            if (reg_wdata_i[`AMX_SRC_LSB +: 9] == '0) begin
                act_q[mix_idx] <= 1'b0;
            end else if (core_system_clock_ok_i) begin
                act_q[mix_idx] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eq_en_q <= '0;
            eq_mode_q <= '0;
            eq_act_q <= '0;
        end else begin
            eq_act_q <= eq_en_q;
            if (reg_wr_i && reg_addr_i == `AMX_EQ_EN_ADDR) begin
                eq_en_q <= reg_wdata_i[3:0];
            end
            if (reg_wr_i && reg_addr_i == `AMX_EQ_MODE_ADDR) begin
                eq_mode_q <= reg_wdata_i[3:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int e = 0; e < 4; e++) begin
                for (int b = 0; b < 5; b++) gain_q[e][b] <= `AMX_GAIN_RST;
                for (int j = 0; j < `AMX_EQ_COEF_WORDS; j++) begin
                    coef_q[e][j] <= '0;
                end
            end
        end else if (reg_wr_i && eq_hit) begin
            case (eq_word)
                5'h00: begin
                    for (int b = 0; b < 4; b++) begin
                        gain_q[eq_sel][b] <= reg_wdata_i[b*8 +: 5];
                    end
                end
                5'h01: gain_q[eq_sel][4] <= reg_wdata_i[4:0];
                default: coef_q[eq_sel][4'(eq_word - 5'h02)] <=
                             reg_wdata_i[15:0];
            endcase
        end
    end

    always_comb begin
        rd_d = '0;
        if (mix_hit) begin
            rd_d[`AMX_SRC_LSB +: 9] = src_q[mix_idx];
            rd_d[`AMX_VOL_LSB +: 7] = vol_q[mix_idx];
            rd_d[`AMX_STS_BIT] = act_q[mix_idx];
        end else if (eq_hit) begin
            case (eq_word)
                5'h00: begin
                    for (int b = 0; b < 4; b++) begin
                        rd_d[b*8 +: 5] = gain_q[eq_sel][b];
                    end
                end
                5'h01: rd_d[4:0] = gain_q[eq_sel][4];
                default: rd_d[15:0] = coef_q[eq_sel][4'(eq_word - 5'h02)];
            endcase
        end else if (reg_addr_i == `AMX_EFFECTS_ENABLED_FLAGS_ADDR) begin
            rd_d[11:0] = {eq_act_q, fx_other_flags_i};
        end else if (reg_addr_i == `AMX_EQ_EN_ADDR) begin
            rd_d[3:0] = eq_en_q;
        end else if (reg_addr_i == `AMX_EQ_MODE_ADDR) begin
            rd_d[3:0] = eq_mode_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
            reg_ack_o <= 1'b0;
        end else begin
            reg_ack_o <= reg_rd_i || reg_wr_i;
            if (reg_rd_i) reg_rdata_o <= rd_d;
        end
    end

    amx_fifo #(
        .WIDTH(NASP * 32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(fifo_ready),
        .in_data_i(asp_data_o),
        .out_valid_o(asp_valid_o),
        .out_ready_i(asp_ready_i),
        .out_data_o()
    );

    default clocking cb_core @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_underclk_refuse: assert property (
        reg_wr_i && mix_hit && reg_wdata_i[8:0] != '0 && !core_system_clock_ok_i &&
        !act_q[mix_idx] |=> !act_q[$past(mix_idx)])
        else $error("path enabled while clock too slow");
    chk_enable_sets_sts: assert property (
        reg_wr_i && mix_hit && reg_wdata_i[8:0] != '0 && core_system_clock_ok_i
        |=> act_q[$past(mix_idx)])
        else $error("path status not set on enable");
    chk_active_kept: assert property (
        act_q[0] && !(reg_wr_i && mix_hit && mix_idx == '0) |=> act_q[0])
        else $error("active path dropped");
    chk_zero_mutes: assert property (
        src_q[0] == '0 |-> smp_w[0] == '0 && !act_q[0])
        else $error("zero source not muted");
    chk_eq_trunc24: assert property (
        smp_w[NASP*4][7:0] == 8'h00 &&
        mix_out[NASP][31:23] inside {9'h000, 9'h1ff})
        else $error("equalizer path wider than 24 bits");
    chk_mix_readback: assert property (
        reg_wr_i && mix_hit ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i)
        |=> reg_rdata_o[8:0] == $past(reg_wdata_i[8:0], 2))
        else $error("mixer field readback mismatch");
    chk_eq_flag_follow: assert property (
        $changed(eq_en_q) |=> eq_act_q == $past(eq_en_q))
        else $error("effects flag did not follow enable");
    chk_eq_bypass: assert property (
        accept && !eq_en_q[0] |=> eq_data_o[23:0] == $past(eq_x[0]))
        else $error("disabled equalizer not bypassed");
    chk_effects_enabled_flags_read: assert property (
        reg_rd_i && reg_addr_i == `AMX_EFFECTS_ENABLED_FLAGS_ADDR
        |=> reg_rdata_o[11:8] == $past(eq_act_q) && reg_rdata_o[31:12] == '0)
        else $error("effects flags read wrong");

    cov_refused_enable: cover property (reg_wr_i && mix_hit &&
        reg_wdata_i[8:0] != '0 && !core_system_clock_ok_i);
    cov_eq_running: cover property (accept && eq_en_q[3]);
    cov_stall: cover property (sample_valid_i && !sample_ready_o);
endmodule : amx_core

// ---- tb/amx_asp_sink.sv ----
module amx_asp_sink (
    // Clock
    input wire logic core_clk_i,
    // Bench control
    input wire logic stall_i,
    // Frame handshake
    input wire logic asp_valid_i,
    output logic asp_ready_o = 1'b0,
    // Frames taken so far
    output int taken_o = 0
);
    timeunit 1ns;
    timeprecision 1ns;

    // Sink runs at the mixer rate, no conversion needed
    // Rate fields are never touched here, so no source reprogramming
    always @(posedge core_clk_i) begin
        if (asp_valid_i === 1'b1 && asp_ready_o) begin
            taken_o <= taken_o + 1;
        end
    end

    always @(negedge core_clk_i) begin
        asp_ready_o <= !stall_i;
    end
endmodule : amx_asp_sink

// ---- tb/amx_core_tb.sv ----
`include "amx_defs.svh"
module amx_core_tb;
    import amx_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_ack_o;
    amx_addr_t reg_addr_i;
    amx_word_t reg_wdata_i, reg_rdata_o;
    logic core_system_clock_ok_i, sample_valid_i, sample_ready_o;
    logic asp_valid_o, asp_ready_i, stall;
    logic [7:0] fx_other_flags_i;
    logic [511:0] src_data_i;
    logic [15:0] src_wide_i;
    logic [639:0] asp_data_o;
    logic [95:0] eq_data_o;
    int mismatches = 0;
    int checked = 0;
    int taken;
    int k;

    amx_core #(.CH(10), .NUM_SRC(16), .FIFO_DEPTH(8)) dut_u (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .core_system_clock_ok_i(core_system_clock_ok_i), .fx_other_flags_i(fx_other_flags_i),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .src_data_i(src_data_i), .src_wide_i(src_wide_i),
        .asp_valid_o(asp_valid_o), .asp_ready_i(asp_ready_i),
        .asp_data_o(asp_data_o), .eq_data_o(eq_data_o)
    );

    amx_asp_sink sink_u (
        .core_clk_i(core_clk_i), .stall_i(stall),
        .asp_valid_i(asp_valid_o), .asp_ready_o(asp_ready_i),
        .taken_o(taken)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task check(input amx_word_t got, input amx_word_t exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    function amx_word_t mw(input amx_vol_t v, input amx_src_t s,
                           input logic st);
        return (32'(v) << `AMX_VOL_LSB) | (32'(st) << `AMX_STS_BIT)
            | 32'(s);
    endfunction : mw

    task wr(input amx_addr_t a, input amx_word_t d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
        check({31'h0, reg_ack_o}, 32'h1);
    endtask : wr

    task rd(input amx_addr_t a, input amx_word_t exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        check({31'h0, reg_ack_o}, 32'h1);
        check(reg_rdata_o, exp);
    endtask : rd

    task push(input int n);
        int got;
        got = 0;
        @(negedge core_clk_i);
        sample_valid_i = 1'b1;
        for (int i = 0; i < 40 && got < n; i++) begin
            if (sample_ready_o === 1'b1) got++;
            @(negedge core_clk_i);
        end
        sample_valid_i = 1'b0;
        check(32'(got), 32'(n));
    endtask : push

    task mix(input logic [31:0] exp);
        @(negedge core_clk_i);
        check(asp_data_o[31:0], exp);
    endtask : mix

    initial begin
        #(50 * 5000);
        mismatches++;
        stop_test;
    end

    initial begin
        rst_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 32'h0;
        core_system_clock_ok_i = 1'b1;
        fx_other_flags_i = 8'h5a;
        sample_valid_i = 1'b0;
        src_data_i = '0;
        src_wide_i = 16'hffff;
        stall = 1'b1;
        repeat (8) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        rd(`AMX_EFFECTS_ENABLED_FLAGS_ADDR, 32'h5a);
        rd(`AMX_EQ_EN_ADDR, 32'h0);
        rd(16'h8200, mw(7'h40, 9'h0, 1'b0));
        rd(`AMX_EQ_GAIN_BASE, 32'h0c0c0c0c);
        rd(16'ha814, 32'h0c);
        rd(`AMX_EQ_MODE_ADDR, 32'h0);
        wr(`AMX_EQ_MODE_ADDR, 32'hf);
        rd(`AMX_EQ_MODE_ADDR, 32'hf);
        wr(16'h8200, mw(7'h40, 9'h1, 1'b0));
        rd(16'h8200, mw(7'h40, 9'h1, 1'b1));
        core_system_clock_ok_i = 1'b0;
        wr(16'h8204, mw(7'h40, 9'h2, 1'b0));
        rd(16'h8204, mw(7'h40, 9'h2, 1'b0));
        wr(16'h8200, mw(7'h40, 9'h1, 1'b0));
        rd(16'h8200, mw(7'h40, 9'h1, 1'b1));
        core_system_clock_ok_i = 1'b1;
        wr(16'h8200, mw(7'h40, 9'h0, 1'b0));
        rd(16'h8200, mw(7'h40, 9'h0, 1'b0));
        wr(16'h833c, mw(7'h46, 9'h3, 1'b0));
        rd(16'h833c, mw(7'h46, 9'h3, 1'b1));
        rd(16'h8340, 32'h0);
        rd(16'h81fc, 32'h0);
        wr(16'h8bbc, mw(7'h40, 9'h3, 1'b0));
        rd(16'h8bbc, mw(7'h40, 9'h3, 1'b1));
        rd(16'h8bc0, 32'h0);
        wr(`AMX_EQ_EN_ADDR, 32'hc);
        rd(`AMX_EQ_EN_ADDR, 32'hc);
        rd(`AMX_EFFECTS_ENABLED_FLAGS_ADDR, 32'hc5a);
        wr(`AMX_EFFECTS_ENABLED_FLAGS_ADDR, 32'hfff);
        rd(`AMX_EFFECTS_ENABLED_FLAGS_ADDR, 32'hc5a);
        // Mixer data path, port zero channel zero
        wr(16'h8200, mw(7'h40, 9'h1, 1'b0));
        wr(16'h8204, mw(7'h40, 9'h2, 1'b0));
        src_data_i[32 +: 32] = 32'h12345678;
        mix(32'h12345678);
        src_data_i[32 +: 32] = 32'h40000000;
        src_data_i[64 +: 32] = 32'h70000000;
        mix(32'h7fffffff);
        src_data_i[64 +: 32] = 32'h0;
        src_data_i[32 +: 32] = 32'h12345678;
        src_wide_i[1] = 1'b0;
        mix(32'h12345600);
        src_wide_i[1] = 1'b1;
        wr(16'h8200, mw(7'h46, 9'h1, 1'b0));
        src_data_i[32 +: 32] = 32'h10000000;
        mix(32'h20000000);
        // Equalizer zero disabled, fill the buffer while the sink stalls
        wr(16'h8b80, mw(7'h40, 9'h1, 1'b0));
        src_data_i[32 +: 32] = 32'h12345678;
        push(8);
        check({31'h0, sample_ready_o}, 32'h0);
        check({31'h0, asp_valid_o}, 32'h1);
        check({8'h0, eq_data_o[23:0]}, 32'h123456);
        check({8'h0, eq_data_o[47:24]}, 32'h0);
        stall = 1'b0;
        k = 0;
        while (taken < 8 && k < 40) begin
            @(negedge core_clk_i);
            k++;
        end
        check(32'(taken), 32'h8);
        check({31'h0, asp_valid_o}, 32'h0);
        check({31'h0, sample_ready_o}, 32'h1);
        stop_test;
    end
endmodule : amx_core_tb
